// >>> core/mtp_sender.sv
// Multi-tap pixel link sender: register port, crossings and tap packer
`timescale 1ns/10ps
module mtp_sender
  import mtp_pkg::*;
#(
  parameter logic WIDE_TAPS = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output mtp_rate_e link_pixel_rate_select,
  input wire logic link_clk,
  input wire logic src_valid,
  input wire mtp_lanes_t src_pix,
  output logic src_ready,
  output mtp_link_s link_out
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LINE = 2'h1,
    ST_GAP = 2'h2,
    ST_DONE = 2'h3
  } mtp_state_e;

  // ---------------- Core clock side ----------------
  mtp_cfg_s live;
  mtp_cfg_s shadow;
  logic err;
  logic start_pend;
  logic req_tgl;
  logic start_tgl;
  logic done_prev;
  logic [7:0] frame_cnt;
  logic [2:0] back_s;

  wire logic hit_ctrl = reg_addr == OFS_CTRL;
  wire logic hit_size = reg_addr == OFS_SIZE;
  wire logic hit_stat = reg_addr == OFS_STAT;
  wire logic hit_rate = reg_addr == OFS_RATE;
  wire logic wr_ctrl = reg_wr && hit_ctrl;
  wire logic wr_size = reg_wr && hit_size;
  wire logic wr_stat = reg_wr && hit_stat;
  wire logic wr_rate = reg_wr && hit_rate;

  wire logic [2:0] w_geom = reg_wdata[CTRL_GEOM_LSB +: 3];
  wire logic [1:0] w_fmt = reg_wdata[CTRL_FMT_LSB +: 2];
  // A rejected write leaves the whole setting untouched
  wire logic ctrl_ok = geom_ok(w_geom, WIDE_TAPS)
    && fmt_ok(w_geom, w_fmt);
  wire logic size_ok = reg_wdata[15:0] != 16'h0000
    && reg_wdata[31:16] != 16'h0000;
  wire logic set_err = (wr_ctrl && !ctrl_ok) || (wr_size && !size_ok);
  wire logic clr_err = wr_stat && reg_wdata[STAT_ERR_BIT];
  wire logic set_start = wr_ctrl && ctrl_ok && reg_wdata[CTRL_START_BIT];

  wire logic cfg_idle = req_tgl == back_s[0];
  wire logic cfg_diff = shadow != live;
  wire logic load_cfg = cfg_idle && cfg_diff;
  // Start waits until the link holds the latest setting
  wire logic issue = start_pend && cfg_idle && !cfg_diff && !reg_wr;
  wire logic done_evt = back_s[1] != done_prev;

  wire mtp_conf_e live_conf = link_conf(live.geom);
  wire logic [31:0] ctrl_word = {25'h0, live.depth12, live.fmt, 1'b0,
                                 live.geom};
  wire logic [31:0] stat_word = {16'h0, frame_cnt, 2'h0, live_conf, 1'b0,
                                 start_pend || !cfg_idle, err, back_s[2]};
  wire logic [31:0] rd_val = hit_ctrl ? ctrl_word
                           : hit_size ? {live.height, live.width}
                           : hit_stat ? stat_word
                           : hit_rate ? {30'h0, link_pixel_rate_select}
                           : 32'h0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      live <= CFG_RST;
      link_pixel_rate_select <= RATE_RST;
    end else begin
      if (wr_ctrl && ctrl_ok) begin
        live.geom <= mtp_geom_e'(w_geom);
        live.fmt <= mtp_fmt_e'(w_fmt);
        live.depth12 <= reg_wdata[CTRL_DEPTH_BIT];
      end
      if (wr_size && size_ok) begin
        live.width <= reg_wdata[15:0];
        live.height <= reg_wdata[SIZE_H_LSB +: 16];
      end
      if (wr_rate) begin
        link_pixel_rate_select <= mtp_rate_e'(reg_wdata[1:0]);
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      err <= 1'b0;
      start_pend <= 1'b0;
      reg_rdata <= '0;
    end else begin
      err <= set_err || (err && !clr_err);
      start_pend <= set_start || (start_pend && !issue);
      reg_rdata <= reg_rd ? rd_val : 32'h0;
    end
  end

  // Shadow is held still until the link acknowledges its copy
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shadow <= CFG_RST;
      req_tgl <= 1'b0;
      start_tgl <= 1'b0;
      done_prev <= 1'b0;
      frame_cnt <= 8'h00;
    end else begin
      if (load_cfg) begin
        shadow <= live;
        req_tgl <= !req_tgl;
      end
      if (issue) begin
        start_tgl <= !start_tgl;
      end
      done_prev <= back_s[1];
      if (done_evt) begin
        frame_cnt <= frame_cnt + 8'h01;
      end
    end
  end

  // ---------------- Link clock side ----------------
  logic link_run;
  logic [1:0] fwd_s;
  logic req_prev;
  logic start_prev;
  logic ack_tgl;
  logic done_tgl;
  logic busy;
  mtp_cfg_s link_cfg;
  mtp_cfg_s frame_cfg;
  mtp_state_e state;
  mtp_state_e next_state;
  logic [15:0] x;
  logic [15:0] y;
  mtp_lanes_t next_lane;
  logic [MAX_TAPS-1:0] next_used;

  // Link reset asserts at once and releases on a link edge
  mtp_sync #(.W(1)) u_rst_sync (
    .clk(link_clk),
    .rst(rst),
    .din(1'b1),
    .dout(link_run)
  );
  wire logic link_rst = !link_run;

  mtp_sync #(.W(2)) u_fwd_sync (
    .clk(link_clk),
    .rst(rst),
    .din({start_tgl, req_tgl}),
    .dout(fwd_s)
  );

  mtp_sync #(.W(3)) u_back_sync (
    .clk(core_clk),
    .rst(rst),
    .din({busy, done_tgl, ack_tgl}),
    .dout(back_s)
  );

  wire logic req_evt = fwd_s[0] != req_prev;
  wire logic start_evt = fwd_s[1] != start_prev;
  wire logic [3:0] taps = tap_count(frame_cfg.geom);
  wire logic [15:0] remain = frame_cfg.width - x;
  wire logic [16:0] sum = {1'b0, x} + {13'h0, taps};
  wire logic [15:0] x_step = sum[15:0];
  wire logic line_last = sum >= {1'b0, frame_cfg.width};
  wire logic take = state == ST_LINE && src_valid && src_ready;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = start_evt ? ST_LINE : ST_IDLE;
      ST_LINE: next_state = (take && line_last) ? ST_GAP : ST_LINE;
      ST_GAP: next_state = (y == frame_cfg.height) ? ST_DONE : ST_LINE;
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Tap i carries pixel x+i; slots past the line end stay empty
  always_comb begin
    next_lane = '0;
    next_used = '0;
    for (int i = 0; i < MAX_TAPS; i++) begin
      next_used[i] = 4'(i) < taps && 16'(i) < remain;
      if (next_used[i]) begin
        next_lane[i] = pix_conv(src_pix[i], frame_cfg.fmt,
                                frame_cfg.depth12);
      end
    end
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      req_prev <= 1'b0;
      start_prev <= 1'b0;
      ack_tgl <= 1'b0;
      link_cfg <= CFG_RST;
    end else begin
      req_prev <= fwd_s[0];
      start_prev <= fwd_s[1];
      if (req_evt) begin
        link_cfg <= shadow;
        ack_tgl <= fwd_s[0];
      end
    end
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      state <= ST_IDLE;
      frame_cfg <= CFG_RST;
      x <= 16'h0000;
      y <= 16'h0000;
      done_tgl <= 1'b0;
      busy <= 1'b0;
      src_ready <= 1'b0;
    end else begin
      state <= next_state;
      busy <= next_state != ST_IDLE;
      src_ready <= next_state == ST_LINE;
      if (state == ST_IDLE && start_evt) begin
        frame_cfg <= link_cfg;
        x <= 16'h0000;
        y <= 16'h0000;
      end else if (take) begin
        x <= line_last ? 16'h0000 : x_step;
        y <= line_last ? y + 16'h0001 : y;
      end
      if (state == ST_DONE) begin
        done_tgl <= !done_tgl;
      end
    end
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      link_out <= '0;
    end else begin
      link_out.lane <= next_lane;
      link_out.tap_used <= take ? next_used : '0;
      link_out.dval <= take;
      link_out.lval <= state == ST_LINE;
      link_out.fval <= state == ST_LINE || state == ST_GAP;
      link_out.base_drive <= 1'b1;
      link_out.mf_drive <= link_conf(frame_cfg.geom) != MTP_BASE;
    end
  end

  // ---------------- Checks ----------------
  sequence s_last_gap;
    state == ST_GAP && y == frame_cfg.height;
  endsequence
  sequence s_frame_close;
    state == ST_DONE ##1 state == ST_IDLE;
  endsequence
  a_full_group: assert property (
    @(posedge link_clk) disable iff (link_rst)
    take && !line_last |=> $countones(link_out.tap_used) == $past(taps))
    else $error("full group does not carry tap count pixels");
  a_pad_tail: assert property (
    @(posedge link_clk) disable iff (link_rst)
    take && line_last |=> link_out.dval
      && $countones(link_out.tap_used) == $past(remain))
    else $error("last group of line not padded correctly");
  a_conf_drive: assert property (
    @(posedge link_clk) disable iff (link_rst)
    link_out.fval |-> link_out.base_drive
      && link_out.mf_drive == (link_conf($past(frame_cfg.geom)) != MTP_BASE))
    else $error("connector drive does not match link configuration");
  a_base_lanes: assert property (
    @(posedge link_clk) disable iff (link_rst)
    link_out.dval && !link_out.mf_drive
      |-> link_out.tap_used[MAX_TAPS-1:BASE_TAPS] == '0)
    else $error("base configuration uses medium or full taps");
  a_line_order: assert property (
    @(posedge link_clk) disable iff (link_rst)
    take && !line_last |=> x == $past(x_step) && y == $past(y))
    else $error("pixel position did not advance by one group");
  a_next_line: assert property (
    @(posedge link_clk) disable iff (link_rst)
    state == ST_GAP && y != frame_cfg.height |=> state == ST_LINE && x == 0)
    else $error("next line did not start after line gap");
  a_frame_end: assert property (
    @(posedge link_clk) disable iff (link_rst)
    s_last_gap |=> s_frame_close)
    else $error("frame did not close after last line");
  a_narrow_out: assert property (
    @(posedge link_clk) disable iff (link_rst)
    take && frame_cfg.fmt == MTP_FMT8 |=> link_out.lane[0][11:8] == 4'h0
      && link_out.lane[0][7:0] == ($past(frame_cfg.depth12)
        ? $past(src_pix[0][11:4]) : $past(src_pix[0][9:2])))
    else $error("eight-bit output not taken from sample MSBs");
  a_geom_legal: assert property (
    @(posedge core_clk) disable iff (rst)
    geom_ok(live.geom, WIDE_TAPS) && fmt_ok(live.geom, live.fmt))
    else $error("illegal geometry or format held");
  a_bad_write: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_ctrl && !ctrl_ok |=> err && live == $past(live))
    else $error("rejected setting was stored or not flagged");
  a_read_slot: assert property (
    @(posedge core_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read answer cycle");

endmodule // mtp_sender

// >>> core/mtp_sync.sv
// Two-stage synchroniser for levels and toggles
`timescale 1ns/10ps
module mtp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // mtp_sync

// >>> inc/mtp_pkg.sv
// Shared constants, types and helpers for the multi-tap pixel link sender
package mtp_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MAX_TAPS = 10;
  localparam int LANE_W = 12;
  localparam int BASE_TAPS = 3;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SIZE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RATE = 8'h0C;

  // Field positions
  localparam int CTRL_GEOM_LSB = 0;
  localparam int CTRL_FMT_LSB = 4;
  localparam int CTRL_DEPTH_BIT = 6;
  localparam int CTRL_START_BIT = 8;
  localparam int SIZE_H_LSB = 16;
  localparam int STAT_ERR_BIT = 1;

  typedef enum logic [2:0] {
    MTP_G2 = 3'h0,
    MTP_G3 = 3'h1,
    MTP_G4 = 3'h2,
    MTP_G6 = 3'h3,
    MTP_G8 = 3'h4,
    MTP_G10 = 3'h5
  } mtp_geom_e;

  typedef enum logic [1:0] {
    MTP_BASE = 2'h0,
    MTP_MEDIUM = 2'h1,
    MTP_FULL = 2'h2
  } mtp_conf_e;

  typedef enum logic [1:0] {
    MTP_FMT8 = 2'h0,
    MTP_FMT10 = 2'h1,
    MTP_FMT12 = 2'h2
  } mtp_fmt_e;

  typedef enum logic [1:0] {
    MTP_R32_5 = 2'h0,
    MTP_R48 = 2'h1,
    MTP_R65 = 2'h2,
    MTP_R82 = 2'h3
  } mtp_rate_e;

  typedef logic [MAX_TAPS-1:0][LANE_W-1:0] mtp_lanes_t;

  typedef struct packed {
    mtp_geom_e geom;
    mtp_fmt_e fmt;
    logic depth12;
    logic [15:0] width;
    logic [15:0] height;
  } mtp_cfg_s;

  typedef struct packed {
    mtp_lanes_t lane;
    logic [MAX_TAPS-1:0] tap_used;
    logic fval;
    logic lval;
    logic dval;
    logic base_drive;
    logic mf_drive;
  } mtp_link_s;

  // Reset values
  localparam mtp_rate_e RATE_RST = MTP_R82;
  localparam mtp_cfg_s CFG_RST = '{geom: MTP_G2, fmt: MTP_FMT8,
    depth12: 1'b1, width: 16'h0010, height: 16'h0004};

  function automatic logic [3:0] tap_count(mtp_geom_e g);
    case (g)
      MTP_G2: return 4'h2;
      MTP_G3: return 4'h3;
      MTP_G4: return 4'h4;
      MTP_G6: return 4'h6;
      MTP_G8: return 4'h8;
      MTP_G10: return 4'hA;
      default: return 4'h2;
    endcase
  endfunction

  function automatic mtp_conf_e link_conf(mtp_geom_e g);
    case (g)
      MTP_G2, MTP_G3: return MTP_BASE;
      MTP_G4, MTP_G6: return MTP_MEDIUM;
      default: return MTP_FULL;
    endcase
  endfunction

  function automatic logic geom_ok(logic [2:0] g, logic wide);
    return (g <= 3'h5) && (wide || g <= 3'h2);
  endfunction

  function automatic logic fmt_ok(logic [2:0] g, logic [1:0] f);
    case (f)
      2'h0: return 1'b1;
      2'h1: return g == 3'h0 || g == 3'h2 || g == 3'h4;
      2'h2: return g == 3'h0 || g == 3'h2;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [11:0] pix_conv(logic [11:0] s, mtp_fmt_e f,
                                           logic d12);
    case (f)
      MTP_FMT8: return d12 ? {4'h0, s[11:4]} : {4'h0, s[9:2]};
      MTP_FMT10: return d12 ? {2'h0, s[11:2]} : {2'h0, s[9:0]};
      MTP_FMT12: return d12 ? s : {s[9:0], 2'h0};
      default: return 12'h000;
    endcase
  endfunction

endpackage

// >>> sim/mtp_grab_model.sv
// Frame grabber model: checks every tap group the sender puts out
`timescale 1ns/10ps
module mtp_grab_model
  import mtp_pkg::*;
(
  input wire logic link_clk,
  input wire logic rst,
  input wire mtp_link_s link_out,
  input wire logic [3:0] taps,
  input wire logic [1:0] fmt,
  input wire logic depth12,
  input wire logic [15:0] width,
  output int groups,
  output int lines,
  output int frames,
  output int bad
);
  int x;
  int y;
  logic lval_q;
  logic fval_q;
  logic used_exp;

  // Pattern differs per pixel and per line so a slip in order shows up
  function automatic logic [11:0] pix(int px, int py);
    return 12'((px * 32'h0B5) ^ (py * 32'h3C1));
  endfunction

  function automatic logic [11:0] conv(logic [11:0] s);
    case (fmt)
      2'h0: return depth12 ? {4'h0, s[11:4]} : {4'h0, s[9:2]};
      2'h1: return depth12 ? {2'h0, s[11:2]} : {2'h0, s[9:0]};
      default: return depth12 ? s : {s[9:0], 2'h0};
    endcase
  endfunction

  always @(posedge link_clk or posedge rst) begin
    if (rst) begin
      x = 0; y = 0; groups = 0; lines = 0; frames = 0; bad = 0;
      lval_q = 1'b0; fval_q = 1'b0;
    end else begin
      if (link_out.lval && !link_out.fval) bad++;
      if (link_out.dval) begin
        groups++;
        if (!link_out.lval) bad++;
        if (link_out.base_drive !== 1'b1) bad++;
        if (link_out.mf_drive !== (taps >= 4'h4)) bad++;
        for (int i = 0; i < MAX_TAPS; i++) begin
          used_exp = i < int'(taps) && x + i < int'(width);
          if (link_out.tap_used[i] !== used_exp) bad++;
          if (link_out.lane[i] !== (used_exp ? conv(pix(x + i, y))
              : 12'h000)) bad++;
        end
        x += int'(taps);
      end else if (link_out.tap_used !== '0) begin
        bad++;
      end
      if (lval_q && !link_out.lval) begin
        if (x < int'(width)) bad++;
        lines++;
        x = 0;
        y++;
      end
      if (fval_q && !link_out.fval) begin
        frames++;
        y = 0;
      end
      lval_q = link_out.lval;
      fval_q = link_out.fval;
    end
  end
endmodule // mtp_grab_model

// >>> sim/tb.sv
// Self-checking bench for the multi-tap pixel link sender
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb;
  import mtp_pkg::*;
  logic core_clk, rst, link_clk, reg_wr, reg_rd, src_valid, src_ready;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, st, ctl;
  mtp_rate_e link_pixel_rate_select;
  mtp_lanes_t src_pix;
  mtp_link_s link_out;
  logic [3:0] m_taps;
  logic [1:0] m_fmt;
  logic m_d12;
  logic [15:0] m_w;
  int error_cnt, checks, cyc, sx, sy, nfr, e_lines, e_groups;
  logic [3:0] tap_tab [6] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA};

  mtp_sender i_mtp_sender (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link_pixel_rate_select(link_pixel_rate_select), .link_clk(link_clk),
    .src_valid(src_valid), .src_pix(src_pix), .src_ready(src_ready),
    .link_out(link_out));

  mtp_grab_model i_mtp_grab_model (.link_clk(link_clk), .rst(rst),
    .link_out(link_out), .taps(m_taps), .fmt(m_fmt), .depth12(m_d12),
    .width(m_w), .groups(), .lines(), .frames(), .bad());

  // Variant without wide geometries sees the same register traffic
  logic [DATA_W-1:0] n_rdata;
  mtp_sender #(.WIDE_TAPS(1'b0)) i_mtp_sender_narrow (.core_clk(core_clk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(n_rdata), .link_pixel_rate_select(),
    .link_clk(link_clk), .src_valid(src_valid), .src_pix(src_pix),
    .src_ready(), .link_out());

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Odd start offset keeps the link clock out of phase with the core
  initial begin
    link_clk = 1'b0;
    #17;
    forever #40 link_clk = ~link_clk;
  end

  // Sensor source: random stalls, a group only advances when taken
  always @(posedge link_clk) begin
    if (src_valid && src_ready) begin
      sx = sx + int'(m_taps);
      if (sx >= int'(m_w)) begin
        sx = 0;
        sy++;
      end
    end
    if (!src_valid || src_ready) src_valid <= ($urandom % 4) != 0;
    for (int i = 0; i < MAX_TAPS; i++)
      src_pix[i] <= i_mtp_grab_model.pix(sx + i, sy);
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      final_report;
    end
  end

  function automatic logic fok(int g, int f);
    return g <= 5 && (f == 0 || (f == 1 && (g == 0 || g == 2 || g == 4))
      || (f == 2 && (g == 0 || g == 2)));
  endfunction

  function automatic logic [1:0] conf_of(int g);
    return g < 2 ? 2'h0 : (g < 4 ? 2'h1 : 2'h2);
  endfunction

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic run_frame(input int g, input int wi);
    int w, h, f, n, t;
    w = wi > 0 ? wi : 1 + $urandom % 25;
    h = 1 + $urandom % 3;
    f = $urandom % 3;
    while (!fok(g, f)) f = $urandom % 3;
    t = int'(tap_tab[g]);
    m_taps = tap_tab[g];
    m_fmt = 2'(f);
    m_d12 = 1'($urandom % 2);
    m_w = 16'(w);
    sx = 0;
    sy = 0;
    wr(OFS_SIZE, {16'(h), 16'(w)});
    wr(OFS_CTRL, 32'(g) | 32'(f) << 4 | 32'(m_d12) << 6 | 32'h100);
    nfr++;
    e_lines += h;
    e_groups += h * ((w + t - 1) / t);
    st = '0;
    for (n = 0; n < 4000 && st[15:8] !== 8'(nfr); n++) rd(OFS_STAT, st);
    `CHK(st[15:8], 8'(nfr))
    `CHK(st[2:0], 3'h0)
    `CHK(i_mtp_grab_model.frames, nfr)
    `CHK(i_mtp_grab_model.lines, e_lines)
    `CHK(i_mtp_grab_model.groups, e_groups)
    `CHK(i_mtp_grab_model.bad, 0)
  endtask

  task final_report;
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0;
    reg_rd = 1'b0; src_valid = 1'b0; src_pix = '0;
    error_cnt = 0; checks = 0; cyc = 0; sx = 0; sy = 0; nfr = 0;
    e_lines = 0; e_groups = 0; ctl = 32'h40;
    m_taps = 4'h2; m_fmt = 2'h0; m_d12 = 1'b1; m_w = 16'h0010;
    void'($urandom(32'h87DF));
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    rd(OFS_CTRL, st); `CHK(st, 32'h40)
    rd(OFS_SIZE, st); `CHK(st, 32'h0004_0010)
    `CHK(link_pixel_rate_select, MTP_R82)
    for (int r = 3; r >= 0; r--) begin
      wr(OFS_RATE, 32'(r));
      rd(OFS_RATE, st); `CHK(st, 32'(r))
      `CHK(link_pixel_rate_select, mtp_rate_e'(r))
    end
    rd(8'h10, st); `CHK(st, 32'h0)
    wr(8'h10, '1);
    rd(OFS_CTRL, st); `CHK(st, ctl)
    wr(OFS_SIZE, 32'h0004_0000);
    rd(OFS_STAT, st); `CHK(st[1], 1'b1)
    rd(OFS_SIZE, st); `CHK(st, 32'h0004_0010)
    wr(OFS_STAT, 32'h2);
    // Every geometry code against every format code, legal or not
    for (int g = 0; g < 8; g++) begin
      for (int f = 0; f < 4; f++) begin
        wr(OFS_CTRL, 32'(g) | 32'(f) << 4 | 32'h40);
        if (fok(g, f)) ctl = 32'(g) | 32'(f) << 4 | 32'h40;
        rd(OFS_STAT, st); `CHK(st[1], !fok(g, f))
        `CHK(n_rdata[1], !(fok(g, f) && g <= 2))
        if (fok(g, f)) `CHK(st[5:4], conf_of(g))
        wr(OFS_STAT, 32'h2);
        rd(OFS_CTRL, st); `CHK(st, ctl)
      end
    end
    run_frame(5, 1);
    run_frame(3, 12);
    run_frame(0, 25);
    for (int k = 0; k < 12; k++) run_frame(k % 6, 0);
    final_report;
  end
endmodule // tb
